//--- design/long_move_pkg.sv
package long_move_pkg;

    // Opcode bytes of the long moves (first byte of the instruction word); the copy from the accumulator is a whole 16-bit word.
    localparam logic [7:0] OP_STORE_PRODUCT = 8'hA9;
    localparam logic [7:0] OP_STORE_MULT = 8'hAB;
    localparam logic [7:0] OP_LOAD_PRODUCT = 8'hA3;
    localparam logic [15:0] OP_PRODUCT_FROM_ACC = 16'hFF5A;
    localparam logic [7:0] OP_REPEAT = 8'hF6;
    localparam logic [7:0] OP_STORE_PTR0 = 8'h3A;
    localparam logic [7:0] OP_STORE_PTR1 = 8'hB2;
    localparam logic [7:0] OP_STORE_PTR2 = 8'hAA;
    localparam logic [7:0] OP_STORE_PTR3 = 8'hA2;
    localparam logic [7:0] OP_STORE_PTR4 = 8'hA8;
    localparam logic [7:0] OP_STORE_PTR5 = 8'hA0;
    localparam logic [7:0] OP_STORE_PTR6 = 8'hC2;
    localparam logic [7:0] OP_STORE_PTR7 = 8'hC3;
    localparam logic [7:0] OP_LOAD_PTR0 = 8'h8E;
    localparam logic [7:0] OP_LOAD_PTR1 = 8'h8B;
    localparam logic [7:0] OP_LOAD_PTR2 = 8'h86;
    localparam logic [7:0] OP_LOAD_PTR3 = 8'h82;
    localparam logic [7:0] OP_LOAD_PTR4 = 8'h8A;
    localparam logic [7:0] OP_LOAD_PTR5 = 8'h83;
    localparam logic [7:0] OP_LOAD_PTR6 = 8'hC4;
    localparam logic [7:0] OP_LOAD_PTR7 = 8'hC5;

    // Field positions inside the 16-bit instruction word, and the sign bit of a 32-bit value.
    localparam int OPC_HI = 15;
    localparam int OPC_LO = 8;
    localparam int LOC_HI = 7;
    localparam int LOC_LO = 0;
    localparam int SIGN_BIT = 31;

    // Step of a post-increment for a 32-bit access, in word addresses.
    localparam logic [31:0] LONG_STEP = 32'h00000002;

    // Reset values.
    localparam logic [31:0] RESET_WORD = 32'h00000000;
    localparam logic [7:0] RESET_COUNT = 8'h00;

    // Register bus offsets (byte addresses, one word each).
    localparam logic [7:0] ADDR_INSTR = 8'h00;
    localparam logic [7:0] ADDR_ACCUM = 8'h04;
    localparam logic [7:0] ADDR_PRODUCT = 8'h08;
    localparam logic [7:0] ADDR_MULT = 8'h0C;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_MEM_RDATA = 8'h14;
    localparam logic [7:0] ADDR_MEM_WDATA = 8'h18;
    localparam logic [7:0] ADDR_MEM_ADDR = 8'h1C;
    localparam logic [7:0] ADDR_PTR_BASE = 8'h20;
    localparam logic [7:0] UNMAPPED_WORD = 8'hEE;
    localparam logic [31:0] UNMAPPED_DATA = 32'hDEADBEEF;

    // Status word bit positions.
    localparam int ST_NEG = 0;
    localparam int ST_ZERO = 1;
    localparam int ST_BUSY = 2;
    localparam int ST_MEM_WR = 3;
    localparam int ST_RPT_LO = 8;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_EXEC = 2'b01,
        ST_DONE = 2'b11
    } exec_state_t;

    typedef enum logic [2:0] {
        K_NONE,
        K_ST_PROD,
        K_ST_MULT,
        K_ST_PTR,
        K_LD_PROD,
        K_LD_PTR,
        K_PROD_ACC,
        K_REPEAT
    } move_kind_t;

    // What the decoder tells the executing stage.
    typedef struct packed {
        move_kind_t kind;
        logic [2:0] ptr;
        logic [7:0] loc;
    } decoded_t;

    // What the addressing unit answers for one operand location.
    typedef struct packed {
        logic [31:0] ea;
        logic is_acc;
        logic upd_en;
        logic [2:0] upd_ptr;
        logic [31:0] upd_val;
        logic pre_mod;
    } addr_result_t;

endpackage : long_move_pkg

//--- design/long_move_decode.sv
`timescale 1ns/10ps
`default_nettype none

module long_move_decode (
    // Instruction word.
    input wire logic [15:0] instr,
    // Decoded move.
    output long_move_pkg::decoded_t dec
);

    // Pure table lookup on the first opcode byte; the full word only for the copy.
    always_comb
    begin
        dec.kind = long_move_pkg::K_NONE;
        dec.ptr = 3'd0;
        dec.loc = instr[long_move_pkg::LOC_HI:long_move_pkg::LOC_LO];
        if (instr == long_move_pkg::OP_PRODUCT_FROM_ACC)
            dec.kind = long_move_pkg::K_PROD_ACC; // [RQ10]
        else
        begin
            case (instr[long_move_pkg::OPC_HI:long_move_pkg::OPC_LO])
                long_move_pkg::OP_STORE_PRODUCT: dec.kind = long_move_pkg::K_ST_PROD; // [RQ1]
                long_move_pkg::OP_STORE_MULT: dec.kind = long_move_pkg::K_ST_MULT; // [RQ9]
                long_move_pkg::OP_LOAD_PRODUCT: dec.kind = long_move_pkg::K_LD_PROD; // [RQ11]
                long_move_pkg::OP_REPEAT: dec.kind = long_move_pkg::K_REPEAT;
                long_move_pkg::OP_STORE_PTR0: begin dec.kind = long_move_pkg::K_ST_PTR; dec.ptr = 3'd0; end // [RQ6]
                long_move_pkg::OP_STORE_PTR1: begin dec.kind = long_move_pkg::K_ST_PTR; dec.ptr = 3'd1; end // [RQ6]
                long_move_pkg::OP_STORE_PTR2: begin dec.kind = long_move_pkg::K_ST_PTR; dec.ptr = 3'd2; end
                long_move_pkg::OP_STORE_PTR3: begin dec.kind = long_move_pkg::K_ST_PTR; dec.ptr = 3'd3; end
                long_move_pkg::OP_STORE_PTR4: begin dec.kind = long_move_pkg::K_ST_PTR; dec.ptr = 3'd4; end
                long_move_pkg::OP_STORE_PTR5: begin dec.kind = long_move_pkg::K_ST_PTR; dec.ptr = 3'd5; end
                long_move_pkg::OP_STORE_PTR6: begin dec.kind = long_move_pkg::K_ST_PTR; dec.ptr = 3'd6; end // [RQ6]
                long_move_pkg::OP_STORE_PTR7: begin dec.kind = long_move_pkg::K_ST_PTR; dec.ptr = 3'd7; end
                long_move_pkg::OP_LOAD_PTR0: begin dec.kind = long_move_pkg::K_LD_PTR; dec.ptr = 3'd0; end // [RQ12]
                long_move_pkg::OP_LOAD_PTR1: begin dec.kind = long_move_pkg::K_LD_PTR; dec.ptr = 3'd1; end
                long_move_pkg::OP_LOAD_PTR2: begin dec.kind = long_move_pkg::K_LD_PTR; dec.ptr = 3'd2; end
                long_move_pkg::OP_LOAD_PTR3: begin dec.kind = long_move_pkg::K_LD_PTR; dec.ptr = 3'd3; end
                long_move_pkg::OP_LOAD_PTR4: begin dec.kind = long_move_pkg::K_LD_PTR; dec.ptr = 3'd4; end
                long_move_pkg::OP_LOAD_PTR5: begin dec.kind = long_move_pkg::K_LD_PTR; dec.ptr = 3'd5; end
                long_move_pkg::OP_LOAD_PTR6: begin dec.kind = long_move_pkg::K_LD_PTR; dec.ptr = 3'd6; end // [RQ12]
                long_move_pkg::OP_LOAD_PTR7: begin dec.kind = long_move_pkg::K_LD_PTR; dec.ptr = 3'd7; end // [RQ12]
                default: dec.kind = long_move_pkg::K_NONE;
            endcase
        end
    end

endmodule : long_move_decode
`default_nettype wire

//--- design/long_move_execute.sv
// Chosen here: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// [RQ1] First opcode byte 1010 1001 with an operand byte decodes as store of the product.
// [RQ2] The store of the product writes all 32 product bits to the addressed location.
// [RQ3] A long store whose destination is the accumulator sets negative from bit 31, else clears it.
// [RQ4] Such a store sets zero when the accumulator is zero, else clears; other targets keep both flags.
// [RQ5] Long moves are not repeatable: after a repeat prefix the count is cleared and the move runs once.
// [RQ6] Pointer stores use opcode bytes 0011 1010, 1011 0010 and 1100 0010 for pointers 0, 1 and 6.
// [RQ7] A pointer store with post-increment of itself writes the old value, then advances the pointer.
// [RQ8] A pointer store with pre-decrement of itself decrements first and stores the new value there.
// [RQ9] Opcode byte 1010 1011 stores the whole multiplicand register to the addressed location.
// [RQ10] The word 1111 1111 0101 1010 copies the accumulator into the product, flags untouched.
// [RQ11] Opcode byte 1010 0011 loads the product from the addressed location, flags untouched.
// [RQ12] Pointer loads use bytes 1000 1110, 1100 0100 and 1100 0101 for pointers 0, 6 and 7.
// [RQ13] A 32-bit access through a post-incremented pointer advances it by two word addresses.
// [RQ14] A pointer load through itself with post-modification keeps the loaded value, not the update.
// [RQ15] The low operand byte of each move goes to the shared addressing unit, which answers the rest.

module long_move_execute (
    // Clock, reset and enable.
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    // Avalon-MM register slave.
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Shared addressing unit.
    output logic [7:0] operand_location,
    input wire long_move_pkg::addr_result_t addr_res,
    // Data memory.
    output logic mem_we,
    output logic [31:0] mem_addr,
    output logic [31:0] mem_wdata,
    input wire logic [31:0] mem_rdata,
    // Status.
    output logic flag_neg,
    output logic flag_zero
);

    long_move_pkg::decoded_t dec;
    long_move_pkg::exec_state_t state_reg;
    logic [15:0] instr_reg;
    logic [31:0] accum_reg;
    logic [31:0] product_reg;
    logic [31:0] multiplicand_reg;
    logic [31:0] aux_pointer_reg [8];
    logic [7:0] repeat_count_reg;
    logic [31:0] mem_rdata_reg;
    logic [31:0] store_val;
    logic [31:0] ptr_sel;
    logic [31:0] acc_after;
    logic is_store;
    logic bus_done_reg;
    logic bus_done_next;
    logic [31:0] rd_next;
    logic go;

    long_move_decode u_decode (
        .instr(instr_reg),
        .dec(dec)
    );

    // Loaded with the word itself, so the addressing answer is ready in the execute cycle.
    always_ff @(posedge clk)
    begin
        if (!reset_n)
            operand_location <= long_move_pkg::RESET_COUNT;
        else if (go && state_reg == long_move_pkg::ST_IDLE)
            operand_location <=
                avs_writedata[long_move_pkg::LOC_HI:long_move_pkg::LOC_LO]; // [RQ15]
    end

    assign go = clk_en && avs_write && !bus_done_reg && (avs_address == long_move_pkg::ADDR_INSTR);
    assign ptr_sel = aux_pointer_reg[dec.ptr];
    assign is_store = (dec.kind == long_move_pkg::K_ST_PROD) || (dec.kind == long_move_pkg::K_ST_MULT)
        || (dec.kind == long_move_pkg::K_ST_PTR);

    // Value to be stored; a pre-decrement of the same pointer stores the decremented value.
    always_comb
    begin
        store_val = long_move_pkg::RESET_WORD;
        case (dec.kind)
            long_move_pkg::K_ST_PROD: store_val = product_reg; // [RQ2]
            long_move_pkg::K_ST_MULT: store_val = multiplicand_reg; // [RQ9]
            long_move_pkg::K_ST_PTR:
            begin
                if (addr_res.upd_en && addr_res.pre_mod && addr_res.upd_ptr == dec.ptr)
                    store_val = addr_res.upd_val; // [RQ8]
                else
                    store_val = ptr_sel; // [RQ7]
            end
            default: store_val = long_move_pkg::RESET_WORD;
        endcase
        acc_after = (is_store && addr_res.is_acc) ? store_val : accum_reg;
    end

    // One instruction per bus write; the execute state lasts one cycle after decode.
    always_ff @(posedge clk)
    begin
        if (!reset_n)
            state_reg <= long_move_pkg::ST_IDLE;
        else if (clk_en)
        begin
            case (state_reg)
                long_move_pkg::ST_IDLE: if (go) state_reg <= long_move_pkg::ST_EXEC;
                long_move_pkg::ST_EXEC: state_reg <= long_move_pkg::ST_DONE;
                long_move_pkg::ST_DONE: state_reg <= long_move_pkg::ST_IDLE;
                default: state_reg <= long_move_pkg::ST_IDLE;
            endcase
        end
    end

    // Instruction holding register, loaded from the bus.
    always_ff @(posedge clk)
    begin
        if (!reset_n)
            instr_reg <= 16'h0000;
        else if (go && state_reg == long_move_pkg::ST_IDLE)
            instr_reg <= avs_writedata[15:0];
    end

    // Memory write port: address from the addressing unit, data chosen above.
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            mem_we <= 1'b0;
            mem_addr <= long_move_pkg::RESET_WORD;
            mem_wdata <= long_move_pkg::RESET_WORD;
        end
        else if (clk_en)
        begin
            mem_we <= (state_reg == long_move_pkg::ST_EXEC) && is_store && !addr_res.is_acc;
            mem_addr <= addr_res.ea;
            mem_wdata <= store_val; // [RQ2]
        end
    end

    // Flags follow the accumulator only when it is the store target.
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            flag_neg <= 1'b0;
            flag_zero <= 1'b0;
        end
        else if (clk_en && state_reg == long_move_pkg::ST_EXEC && is_store && addr_res.is_acc)
        begin
            flag_neg <= acc_after[long_move_pkg::SIGN_BIT]; // [RQ3]
            flag_zero <= (acc_after == long_move_pkg::RESET_WORD); // [RQ4]
        end
    end

    // Accumulator: written by software or by a store naming it.
    always_ff @(posedge clk)
    begin
        if (!reset_n)
            accum_reg <= long_move_pkg::RESET_WORD;
        else if (clk_en && state_reg == long_move_pkg::ST_EXEC)
            accum_reg <= acc_after;
        else if (clk_en && avs_write && !bus_done_reg && avs_address == long_move_pkg::ADDR_ACCUM)
            accum_reg <= avs_writedata;
    end

    // Product and multiplicand registers; loads leave the flags alone.
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            product_reg <= long_move_pkg::RESET_WORD;
            multiplicand_reg <= long_move_pkg::RESET_WORD;
        end
        else if (clk_en && state_reg == long_move_pkg::ST_EXEC)
        begin
            if (dec.kind == long_move_pkg::K_PROD_ACC)
                product_reg <= accum_reg; // [RQ10]
            else if (dec.kind == long_move_pkg::K_LD_PROD)
                product_reg <= mem_rdata; // [RQ11]
        end
        else if (clk_en && avs_write && !bus_done_reg)
        begin
            if (avs_address == long_move_pkg::ADDR_PRODUCT)
                product_reg <= avs_writedata;
            if (avs_address == long_move_pkg::ADDR_MULT)
                multiplicand_reg <= avs_writedata;
        end
    end

    // Pointer file; the load wins over any modification of the same pointer.
    generate
        for (genvar i = 0; i < 8; i++)
        begin : g_ptr
            always_ff @(posedge clk)
            begin
                if (!reset_n)
                    aux_pointer_reg[i] <= long_move_pkg::RESET_WORD;
                else if (clk_en && state_reg == long_move_pkg::ST_EXEC)
                begin
                    if (dec.kind == long_move_pkg::K_LD_PTR && dec.ptr == i)
                        aux_pointer_reg[i] <= mem_rdata; // [RQ12] [RQ14]
                    else if (dec.kind != long_move_pkg::K_NONE && addr_res.upd_en
                        && addr_res.upd_ptr == i)
                        aux_pointer_reg[i] <= addr_res.upd_val; // [RQ7] [RQ13]
                end
                else if (clk_en && avs_write && !bus_done_reg
                    && avs_address == long_move_pkg::ADDR_PTR_BASE + 8'(i * 4))
                    aux_pointer_reg[i] <= avs_writedata;
            end
        end
    endgenerate

    // Repeat prefix loads the count; any long move clears it and runs once.
    always_ff @(posedge clk)
    begin
        if (!reset_n)
            repeat_count_reg <= long_move_pkg::RESET_COUNT;
        else if (clk_en && state_reg == long_move_pkg::ST_EXEC)
        begin
            if (dec.kind == long_move_pkg::K_REPEAT)
                repeat_count_reg <= dec.loc;
            else if (dec.kind != long_move_pkg::K_NONE)
                repeat_count_reg <= long_move_pkg::RESET_COUNT; // [RQ5]
        end
    end

    // Memory read data capture for software visibility.
    always_ff @(posedge clk)
    begin
        if (!reset_n)
            mem_rdata_reg <= long_move_pkg::RESET_WORD;
        else if (clk_en && state_reg == long_move_pkg::ST_EXEC)
            mem_rdata_reg <= mem_rdata;
    end

    // Read mux; pointer words sit above the fixed registers.
    always_comb
    begin
        rd_next = long_move_pkg::UNMAPPED_DATA;
        if (avs_address == long_move_pkg::ADDR_INSTR)
            rd_next = {16'h0000, instr_reg};
        else if (avs_address == long_move_pkg::ADDR_ACCUM)
            rd_next = accum_reg;
        else if (avs_address == long_move_pkg::ADDR_PRODUCT)
            rd_next = product_reg;
        else if (avs_address == long_move_pkg::ADDR_MULT)
            rd_next = multiplicand_reg;
        else if (avs_address == long_move_pkg::ADDR_STATUS)
            rd_next = {16'h0000, repeat_count_reg, 4'h0, mem_we,
                state_reg != long_move_pkg::ST_IDLE, flag_zero, flag_neg};
        else if (avs_address == long_move_pkg::ADDR_MEM_RDATA)
            rd_next = mem_rdata_reg;
        else if (avs_address == long_move_pkg::ADDR_MEM_WDATA)
            rd_next = mem_wdata;
        else if (avs_address == long_move_pkg::ADDR_MEM_ADDR)
            rd_next = mem_addr;
        else if (avs_address >= long_move_pkg::ADDR_PTR_BASE && avs_address < 8'h40
            && avs_address[1:0] == 2'b00)
            rd_next = aux_pointer_reg[avs_address[4:2]];
    end

    // Every access waits one cycle; a write to the instruction word waits while busy.
    assign bus_done_next = (avs_read || avs_write) && !bus_done_reg
        && !(avs_write && avs_address == long_move_pkg::ADDR_INSTR
        && state_reg != long_move_pkg::ST_IDLE);

    // Waitrequest has its own flop so the bus never sees an inverter after a register.
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            bus_done_reg <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata <= long_move_pkg::RESET_WORD;
        end
        else if (clk_en)
        begin
            bus_done_reg <= bus_done_next;
            avs_waitrequest <= !bus_done_next;
            avs_readdata <= rd_next;
        end
    end

    a_flags_hold: assert property (@(posedge clk) disable iff (!reset_n)
        (clk_en && state_reg == long_move_pkg::ST_EXEC && !(is_store && addr_res.is_acc))
        |=> $stable(flag_neg) && $stable(flag_zero)) // [RQ4]
        else $error("flags changed without an accumulator store");
    a_neg_flag: assert property (@(posedge clk) disable iff (!reset_n)
        (clk_en && state_reg == long_move_pkg::ST_EXEC && is_store && addr_res.is_acc)
        |=> flag_neg == accum_reg[31]) // [RQ3]
        else $error("negative flag wrong");
    a_zero_flag: assert property (@(posedge clk) disable iff (!reset_n)
        (clk_en && state_reg == long_move_pkg::ST_EXEC && is_store && addr_res.is_acc)
        |=> flag_zero == (accum_reg == 32'h00000000)) // [RQ4]
        else $error("zero flag wrong");
    a_rpt_cleared: assert property (@(posedge clk) disable iff (!reset_n)
        (clk_en && state_reg == long_move_pkg::ST_EXEC && dec.kind != long_move_pkg::K_NONE
        && dec.kind != long_move_pkg::K_REPEAT) |=> repeat_count_reg == 8'h00) // [RQ5]
        else $error("repeat count not cleared");
    a_prod_copy: assert property (@(posedge clk) disable iff (!reset_n)
        (clk_en && state_reg == long_move_pkg::ST_EXEC && dec.kind == long_move_pkg::K_PROD_ACC)
        |=> product_reg == $past(accum_reg)) // [RQ10]
        else $error("product copy wrong");
    a_store_data: assert property (@(posedge clk) disable iff (!reset_n)
        (clk_en && state_reg == long_move_pkg::ST_EXEC && dec.kind == long_move_pkg::K_ST_PROD
        && !addr_res.is_acc) |=> mem_we && mem_wdata == $past(product_reg)) // [RQ2]
        else $error("product store wrong");
    a_ptr_load: assert property (@(posedge clk) disable iff (!reset_n)
        (clk_en && state_reg == long_move_pkg::ST_EXEC && dec.kind == long_move_pkg::K_LD_PTR)
        |=> aux_pointer_reg[$past(dec.ptr)] == $past(mem_rdata)) // [RQ14]
        else $error("pointer load lost");
    a_loc_passed: assert property (@(posedge clk) disable iff (!reset_n)
        operand_location == instr_reg[7:0]) // [RQ15]
        else $error("operand location not passed");
    c_store_acc: cover property (@(posedge clk) state_reg == long_move_pkg::ST_EXEC
        && is_store && addr_res.is_acc);
    c_ptr_load: cover property (@(posedge clk) state_reg == long_move_pkg::ST_EXEC
        && dec.kind == long_move_pkg::K_LD_PTR);
    c_repeat: cover property (@(posedge clk) state_reg == long_move_pkg::ST_EXEC
        && dec.kind == long_move_pkg::K_REPEAT);

endmodule : long_move_execute
`default_nettype wire

//--- sim/operand_memory_model.sv
`timescale 1ns/10ps
`default_nettype none

module operand_memory_model (
    // Clock.
    input wire logic clk,
    // Addressing request and the pointer value that the bench says is in use.
    input wire logic [7:0] operand_location,
    input wire logic [31:0] ptr_now,
    output long_move_pkg::addr_result_t addr_res,
    // Data memory port.
    input wire logic mem_we,
    input wire logic [31:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    output logic [31:0] mem_rdata
);
    logic [31:0] mem [256];

    // Location 00 is the accumulator, 1p post-increments pointer p, 2p pre-decrements it.
    always_comb
    begin
        addr_res = '0;
        addr_res.ea = {24'h000000, operand_location};
        addr_res.is_acc = (operand_location == 8'h00);
        addr_res.upd_ptr = operand_location[2:0];
        if (operand_location[7:4] == 4'h1)
        begin
            addr_res.ea = ptr_now;
            addr_res.upd_en = 1'b1;
            addr_res.upd_val = ptr_now + long_move_pkg::LONG_STEP;
        end
        else if (operand_location[7:4] == 4'h2)
        begin
            addr_res.ea = ptr_now - long_move_pkg::LONG_STEP;
            addr_res.upd_en = 1'b1;
            addr_res.upd_val = ptr_now - long_move_pkg::LONG_STEP;
            addr_res.pre_mod = 1'b1;
        end
    end

    // Reads see the effective address at once, since this memory has no wait states.
    assign mem_rdata = mem[addr_res.ea[7:0]];

    // Cells start as a known pattern so a load from an untouched cell can still be checked.
    initial
    begin
        for (int i = 0; i < 256; i++)
            mem[i] = 32'h5A000000 | 32'(i);
    end
    always @(posedge clk)
    begin
        if (mem_we === 1'b1)
            mem[mem_addr[7:0]] <= mem_wdata;
    end
endmodule : operand_memory_model

`default_nettype wire

//--- sim/tb.sv
`timescale 1ns/10ps
`default_nettype none

module tb;
    logic clk, reset_n, avs_read, avs_write, avs_waitrequest, mem_we, flag_neg, flag_zero;
    logic [7:0] avs_address, operand_location;
    logic [31:0] avs_writedata, avs_readdata, mem_addr, mem_wdata, mem_rdata, ptr_now, rd, fl;
    long_move_pkg::addr_result_t addr_res;
    int we_count = 0, n0;
    int miscompares = 0;
    int tests_run = 0;
    logic [7:0] st_op [3] = '{long_move_pkg::OP_STORE_PTR0, long_move_pkg::OP_STORE_PTR1,
        long_move_pkg::OP_STORE_PTR6};
    logic [7:0] ld_op [3] = '{long_move_pkg::OP_LOAD_PTR0, long_move_pkg::OP_LOAD_PTR6,
        long_move_pkg::OP_LOAD_PTR7};
    int st_n [3] = '{0, 1, 6};
    int ld_n [3] = '{0, 6, 7};

    long_move_execute dut (.clk, .reset_n, .clk_en(1'b1), .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_readdata, .avs_waitrequest, .operand_location, .addr_res,
        .mem_we, .mem_addr, .mem_wdata, .mem_rdata, .flag_neg, .flag_zero);
    operand_memory_model mem_i (.clk, .operand_location, .ptr_now, .addr_res, .mem_we,
        .mem_addr, .mem_wdata, .mem_rdata);

    // Free-running clock.
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Memory writes are counted to show that a move runs exactly once.
    always @(posedge clk)
    begin
        if (mem_we === 1'b1)
            we_count <= we_count + 1;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // One bus cycle held until waitrequest is sampled low, then one idle edge before the next.
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0)
            @(posedge clk);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk);
    endtask : bus

    // Issue one instruction, then read status so its memory write has landed.
    task automatic run(input logic [15:0] w);
        bus(1'b1, long_move_pkg::ADDR_INSTR, {16'h0000, w});
        bus(1'b0, long_move_pkg::ADDR_STATUS, 32'h00000000);
    endtask : run

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : complete_run

    // A hung handshake ends the run here.
    initial
    begin
        repeat (5000) @(posedge clk);
        miscompares++;
        complete_run();
    end

    initial
    begin
        reset_n = 1'b0;
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h00000000;
        ptr_now = 32'h00000000;
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        bus(1'b0, long_move_pkg::ADDR_STATUS, 32'h00000000);
        check(rd, 32'h00000000);
        bus(1'b1, long_move_pkg::UNMAPPED_WORD, 32'h00000001);
        bus(1'b0, long_move_pkg::UNMAPPED_WORD, 32'h00000000);
        check(rd, long_move_pkg::UNMAPPED_DATA);
        $display("test reset_and_unmapped done");
        bus(1'b1, long_move_pkg::ADDR_PRODUCT, 32'h80000001);
        run({long_move_pkg::OP_STORE_PRODUCT, 8'h40});
        check(mem_i.mem[8'h40], 32'h80000001);
        check({24'h000000, operand_location}, 32'h00000040);
        run({long_move_pkg::OP_STORE_PRODUCT, 8'h00});
        bus(1'b0, long_move_pkg::ADDR_ACCUM, 32'h00000000);
        check(rd, 32'h80000001);
        check({30'h00000000, flag_zero, flag_neg}, 32'h00000001);
        bus(1'b1, long_move_pkg::ADDR_PRODUCT, 32'h00000000);
        run({long_move_pkg::OP_STORE_PRODUCT, 8'h00});
        check({30'h00000000, flag_zero, flag_neg}, 32'h00000002);
        bus(1'b1, long_move_pkg::ADDR_MULT, 32'h92345678);
        run({long_move_pkg::OP_STORE_MULT, 8'h41});
        check(mem_i.mem[8'h41], 32'h92345678);
        check({30'h00000000, flag_zero, flag_neg}, 32'h00000002);
        $display("test stores done");
        for (int i = 0; i < 3; i++)
        begin
            bus(1'b1, long_move_pkg::ADDR_PTR_BASE + 8'(4 * st_n[i]), 32'h00000A00 + 32'(i));
            run({st_op[i], 8'h50 + 8'(i)});
            check(mem_i.mem[8'h50 + 8'(i)], 32'h00000A00 + 32'(i));
        end
        bus(1'b1, long_move_pkg::ADDR_PTR_BASE + 8'h18, 32'h00000030);
        ptr_now <= 32'h00000030;
        run({long_move_pkg::OP_STORE_PTR6, 8'h16});
        check(mem_i.mem[8'h30], 32'h00000030);
        bus(1'b0, long_move_pkg::ADDR_PTR_BASE + 8'h18, 32'h00000000);
        check(rd, 32'h00000032);
        bus(1'b1, long_move_pkg::ADDR_PTR_BASE + 8'h04, 32'h00000038);
        ptr_now <= 32'h00000038;
        run({long_move_pkg::OP_STORE_PTR1, 8'h21});
        check(mem_i.mem[8'h36], 32'h00000036);
        bus(1'b0, long_move_pkg::ADDR_PTR_BASE + 8'h04, 32'h00000000);
        check(rd, 32'h00000036);
        $display("test pointer_stores done");
        bus(1'b1, long_move_pkg::ADDR_ACCUM, 32'hCAFE0001);
        fl = {30'h00000000, flag_zero, flag_neg};
        run(long_move_pkg::OP_PRODUCT_FROM_ACC);
        bus(1'b0, long_move_pkg::ADDR_PRODUCT, 32'h00000000);
        check(rd, 32'hCAFE0001);
        check({30'h00000000, flag_zero, flag_neg}, fl);
        run({long_move_pkg::OP_LOAD_PRODUCT, 8'h42});
        bus(1'b0, long_move_pkg::ADDR_PRODUCT, 32'h00000000);
        check(rd, 32'h5A000042);
        for (int i = 0; i < 3; i++)
        begin
            run({ld_op[i], 8'h60 + 8'(i)});
            bus(1'b0, long_move_pkg::ADDR_PTR_BASE + 8'(4 * ld_n[i]), 32'h00000000);
            check(rd, 32'h5A000060 + 32'(i));
        end
        check({30'h00000000, flag_zero, flag_neg}, fl);
        bus(1'b1, long_move_pkg::ADDR_PTR_BASE + 8'h1C, 32'h00000044);
        ptr_now <= 32'h00000044;
        run({long_move_pkg::OP_LOAD_PTR7, 8'h17});
        bus(1'b0, long_move_pkg::ADDR_PTR_BASE + 8'h1C, 32'h00000000);
        check(rd, 32'h5A000044);
        $display("test loads done");
        run({long_move_pkg::OP_REPEAT, 8'h05});
        check({24'h000000, rd[15:8]}, 32'h00000005);
        n0 = we_count;
        run({long_move_pkg::OP_STORE_PRODUCT, 8'h43});
        check({24'h000000, rd[15:8]}, 32'h00000000);
        check(32'(we_count - n0), 32'h00000001);
        $display("test repeat_prefix done");
        complete_run();
    end
endmodule : tb

`default_nettype wire
